/* File: cxd_defs.svh */
// constants for the clear/decrement/call execute slice
// assumes inclusion by bare name from the package and the modules
`ifndef CXD_DEFS_SVH
`define CXD_DEFS_SVH

// register port offsets (word index)
`define CXD_OFF_WORK 3'h0
`define CXD_OFF_UPLATCH 3'h1
`define CXD_OFF_STATUS 3'h2
`define CXD_OFF_PC_LO 3'h3
`define CXD_OFF_PC_HI 3'h4
`define CXD_OFF_WDOG 3'h5

// status field positions
`define CXD_ST_ZERO 0
`define CXD_ST_PD_N 3
`define CXD_ST_TO_N 4

// reset values
`define CXD_RST_WORK 8'h00
`define CXD_RST_UPLATCH 7'h00
`define CXD_RST_PC 15'h0000
`define CXD_RST_ZERO 1'b0
`define CXD_RST_FLAG_N 1'b1

// operation constants
`define CXD_CLEAR_VAL 8'h00
`define CXD_DEC_STEP 8'h01
`define CXD_PC_STEP 15'h0001
`define CXD_WDOG_CLR_VAL 8'h00
`define CXD_PRE_CLR_VAL 8'h00

`endif

/* File: cxd_pkg.sv */
// types for the clear/decrement/call execute slice
// assumes cxd_defs.svh is on the include path
package cxd_pkg;
  `include "cxd_defs.svh"

  // decoded operation handed in by the decoder front
  typedef enum logic [2:0] {
    CXD_OP_NONE = 3'b000,
    CXD_OP_WDOG_CLR = 3'b001,
    CXD_OP_CALL_W = 3'b010,
    CXD_OP_COMPL = 3'b011,
    CXD_OP_CLR_F = 3'b100,
    CXD_OP_DEC_F = 3'b101,
    CXD_OP_CLR_W = 3'b110,
    CXD_OP_DEC_SKIP = 3'b111
  } cxd_op_t;

  // execute sequencer states
  typedef enum logic [1:0] {
    CXD_ST_IDLE = 2'b00,
    CXD_ST_CALL2 = 2'b01,
    CXD_ST_SKIP = 2'b10
  } cxd_state_t;
endpackage

/* File: cxd_watchdog.sv */
// watchdog counter with prescaler, cleared by the execute slice
// assumes one clock; clear is a one-cycle pulse from the same domain
`include "cxd_defs.svh"
module cxd_watchdog import cxd_pkg::*; #(
  parameter int PRE_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wdog_clear,
  input wire logic wdog_enable,
  output logic [CNT_W-1:0] wdog_count,
  output logic wdog_timeout
);
  // refuse widths the counters cannot serve
  generate
    if (PRE_W < 1 || PRE_W > 8 || CNT_W < 1 || CNT_W > 8) begin : g_bad
      $error("cxd_watchdog: widths must be 1..8");
    end
  endgenerate

  logic [PRE_W-1:0] pre_reg; // prescaler count
  logic [CNT_W-1:0] cnt_reg; // watchdog_counter value
  logic to_reg; // one-cycle timeout pulse
  wire pre_wrap = &pre_reg; // prescaler about to roll
  wire cnt_wrap = &cnt_reg; // counter about to roll

  // counting; clear returns both stages to zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_reg <= '0;
      cnt_reg <= '0;
      to_reg <= 1'b0;
    end else if (wdog_clear) begin
      pre_reg <= PRE_W'(`CXD_PRE_CLR_VAL);
      cnt_reg <= CNT_W'(`CXD_WDOG_CLR_VAL);
      to_reg <= 1'b0;
    end else if (wdog_enable) begin
      pre_reg <= pre_reg + 1'b1;
      cnt_reg <= pre_wrap ? cnt_reg + 1'b1 : cnt_reg;
      to_reg <= pre_wrap && cnt_wrap;
    end else begin
      to_reg <= 1'b0;
    end
  end

  assign wdog_count = cnt_reg;
  assign wdog_timeout = to_reg;
endmodule // cxd_watchdog

/* File: cxd_exec.sv */
// execute slice for watchdog clear, call via work reg, complement,
// clear, decrement and decrement-skip operations
// assumes decoded op from the fetch stage on the same clock and a
// register file whose read data is valid beside the request
//
// Contract
// - watchdog clear zeroes counter, sets both flags
// - watchdog clear also zeroes the prescaler
// - indirect call pushes pc plus one first
// - pc low from work, high from latch
// - indirect call two cycles, flags unchanged
// - complement routes by destination, updates zero
// - clear file writes zero, sets zero
// - decrement routes by destination, updates zero
// - clear work writes zero, sets zero
// - decrement-skip routes result, flags untouched
// - zero result discards next, two cycles
`include "cxd_defs.svh"
module cxd_exec import cxd_pkg::*; #(
  parameter int PRE_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input cxd_op_t op_sel,
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [6:0] file_addr,
  input wire logic dest_file,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [6:0] file_waddr,
  output logic [7:0] file_wdata,
  output logic stack_push,
  output logic [14:0] return_stack_top,
  output logic [14:0] pc_out,
  output logic skip_flush,
  input wire logic sleep_enter,
  input wire logic wdog_enable,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // sequencer and architectural state
  cxd_state_t state_reg, state_next; // execute sequencer
  logic [7:0] work_reg; // working register
  logic [6:0] upper_pc_latch_reg; // upper_pc_latch
  logic [14:0] pc_reg; // program counter
  logic zero_reg; // zero flag
  logic timeout_status_n_reg; // active-low timeout flag
  logic powerdown_status_n_reg; // active-low power-down flag
  logic fwe_reg; // file write strobe
  logic [6:0] fwa_reg; // file write address
  logic [7:0] fwd_reg; // file write data
  logic push_reg; // stack push strobe
  logic [14:0] tos_reg; // pushed return address
  logic flush_reg; // skip-cycle marker
  logic [7:0] rdata_reg; // register port read data
  logic [CNT_W-1:0] wdog_count; // watchdog count view
  logic wdog_timeout; // watchdog expiry pulse

  // result arithmetic shared by several ops
  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = v - `CXD_DEC_STEP;
  endfunction

  function automatic logic is_zero8(input logic [7:0] v);
    is_zero8 = (v == `CXD_CLEAR_VAL);
  endfunction

  // handshake: a new op is taken only when idle
  assign op_ready = (state_reg == CXD_ST_IDLE);
  wire take = op_valid && op_ready; // op accepted this edge

  // per-op decode
  wire is_wclr = take && (op_sel == CXD_OP_WDOG_CLR);
  wire is_call_via_work_reg_op = take && (op_sel == CXD_OP_CALL_W);
  wire is_complement_file_op = take && (op_sel == CXD_OP_COMPL);
  wire is_clear_file_op = take && (op_sel == CXD_OP_CLR_F);
  wire is_decrement_file_op = take && (op_sel == CXD_OP_DEC_F);
  wire is_clear_work_reg_op = take && (op_sel == CXD_OP_CLR_W);
  wire is_dsz = take && (op_sel == CXD_OP_DEC_SKIP);
  wire is_none = take && (op_sel == CXD_OP_NONE);

  wire [7:0] comp_res = ~file_rdata;
  // decrement result, shared with the skip form
  wire [7:0] dec_res = dec8(file_rdata);
  // result of whichever routed op runs
  wire [7:0] alu_res = is_complement_file_op ? comp_res : dec_res;
  wire routed = is_complement_file_op || is_decrement_file_op || is_dsz; // op uses dest bit
  wire to_file = routed && dest_file; // result goes to file
  wire to_work = routed && !dest_file; // result goes to work
  // skip taken when decremented value is zero
  wire skip_hit = is_dsz && is_zero8(dec_res);
  wire pc_plus1 = take && !is_call_via_work_reg_op; // sequential advance
  wire [14:0] pc_inc = pc_reg + `CXD_PC_STEP; // next address

  // register port decode
  wire wr_work = reg_wr && (reg_addr == `CXD_OFF_WORK);
  wire wr_latch = reg_wr && (reg_addr == `CXD_OFF_UPLATCH);
  wire wr_status = reg_wr && (reg_addr == `CXD_OFF_STATUS);

  // status byte as seen by software
  wire [7:0] status_view = {3'h0, timeout_status_n_reg,
    powerdown_status_n_reg, 2'h0, zero_reg};

  // read multiplexer; unmapped offsets read zero
  wire [7:0] rd_mux =
    (reg_addr == `CXD_OFF_WORK) ? work_reg :
    (reg_addr == `CXD_OFF_UPLATCH) ? {1'b0, upper_pc_latch_reg} :
    (reg_addr == `CXD_OFF_STATUS) ? status_view :
    (reg_addr == `CXD_OFF_PC_LO) ? pc_reg[7:0] :
    (reg_addr == `CXD_OFF_PC_HI) ? {1'b0, pc_reg[14:8]} :
    (reg_addr == `CXD_OFF_WDOG) ? 8'(wdog_count) : 8'h00;

  // watchdog with prescaler, cleared by the op
  cxd_watchdog #(.PRE_W(PRE_W), .CNT_W(CNT_W)) u_wdog (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wdog_clear(is_wclr),
    .wdog_enable(wdog_enable),
    .wdog_count(wdog_count),
    .wdog_timeout(wdog_timeout)
  );

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CXD_ST_IDLE: begin
        // indirect call takes a second cycle
        if (is_call_via_work_reg_op) begin
          state_next = CXD_ST_CALL2;
        // zero result inserts a nop cycle
        end else if (skip_hit) begin
          state_next = CXD_ST_SKIP;
        end
      end
      CXD_ST_CALL2: state_next = CXD_ST_IDLE;
      CXD_ST_SKIP: state_next = CXD_ST_IDLE;
      default: state_next = CXD_ST_IDLE;
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) state_reg <= CXD_ST_IDLE;
    else state_reg <= state_next;
  end

  // program counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= `CXD_RST_PC;
    // target from work and latch after the push
    end else if (state_reg == CXD_ST_CALL2) begin
      pc_reg <= {upper_pc_latch_reg, work_reg};
    // discarded slot still consumes its address
    end else if (pc_plus1 || state_reg == CXD_ST_SKIP) begin
      pc_reg <= pc_inc;
    end
  end

  // return stack push
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      push_reg <= 1'b0;
      tos_reg <= `CXD_RST_PC;
    end else begin
      // push next address before the jump
      push_reg <= is_call_via_work_reg_op;
      if (is_call_via_work_reg_op) tos_reg <= pc_inc;
    end
  end

  // working register; execution beats the port
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      work_reg <= `CXD_RST_WORK;
    end else if (is_clear_work_reg_op) begin
      work_reg <= `CXD_CLEAR_VAL;
    // routed results land in work when dest is 0
    end else if (to_work) begin
      work_reg <= alu_res;
    end else if (wr_work) begin
      work_reg <= reg_wdata;
    end
  end

  // upper address latch, software written
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) upper_pc_latch_reg <= `CXD_RST_UPLATCH;
    else if (wr_latch) upper_pc_latch_reg <= reg_wdata[6:0];
  end

  // zero flag
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      zero_reg <= `CXD_RST_ZERO;
    // clear file and clear work force zero set
    end else if (is_clear_file_op || is_clear_work_reg_op) begin
      zero_reg <= 1'b1;
    end else if (is_complement_file_op || is_decrement_file_op) begin
      zero_reg <= is_zero8(alu_res);
    end else if (wr_status) begin
      zero_reg <= reg_wdata[`CXD_ST_ZERO];
    end
  end

  // active-low timeout and power-down flags
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      timeout_status_n_reg <= `CXD_RST_FLAG_N;
      powerdown_status_n_reg <= `CXD_RST_FLAG_N;
    end else begin
      // expiry wins over a clear in the same cycle
      if (wdog_timeout) timeout_status_n_reg <= 1'b0;
      else if (is_wclr) timeout_status_n_reg <= 1'b1;
      if (sleep_enter) powerdown_status_n_reg <= 1'b0;
      else if (is_wclr) powerdown_status_n_reg <= 1'b1;
    end
  end

  // file write port
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fwe_reg <= 1'b0;
      fwa_reg <= 7'h00;
      fwd_reg <= 8'h00;
    end else begin
      fwe_reg <= is_clear_file_op || to_file;
      if (is_clear_file_op || to_file) begin
        fwa_reg <= file_addr;
        fwd_reg <= is_clear_file_op ? `CXD_CLEAR_VAL : alu_res;
      end
    end
  end

  // skip marker and read data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flush_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      flush_reg <= skip_hit;
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // outputs
  assign file_we = fwe_reg;
  assign file_waddr = fwa_reg;
  assign file_wdata = fwd_reg;
  assign stack_push = push_reg;
  assign return_stack_top = tos_reg;
  assign pc_out = pc_reg;
  assign skip_flush = flush_reg;
  assign reg_rdata = rdata_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_wclr_flags: assert property (
    is_wclr && !wdog_timeout && !sleep_enter |=>
      timeout_status_n_reg && powerdown_status_n_reg)
    else $error("watchdog clear left a status flag low");

  a_wclr_count: assert property (
    is_wclr |=> wdog_count == '0)
    else $error("watchdog count not cleared");

  a_call_push: assert property (
    is_call_via_work_reg_op |=> stack_push && return_stack_top == $past(pc_reg) + 15'h1)
    else $error("indirect call pushed wrong address");

  // pc loaded from work and latch
  a_call_target: assert property (
    is_call_via_work_reg_op && !wr_work && !wr_latch ##1 1'b1 |=>
      pc_out == {$past(upper_pc_latch_reg, 2), $past(work_reg, 2)})
    else $error("indirect call target wrong");

  a_call_cycles: assert property (
    is_call_via_work_reg_op && !wr_status |=> !op_ready ##1 op_ready)
    else $error("indirect call not two cycles");

  // zero flag kept across the call
  a_call_zero: assert property (
    is_call_via_work_reg_op && !wr_status |=> $stable(zero_reg))
    else $error("indirect call changed the zero flag");

  a_comp_file: assert property (
    is_complement_file_op && dest_file |=> file_we && file_wdata == ~$past(file_rdata))
    else $error("complement result wrong");

  // clear file writes zero and sets zero
  a_clear_file_op_zero: assert property (
    is_clear_file_op |=> file_we && file_wdata == 8'h00 && zero_reg)
    else $error("clear file result wrong");

  a_dec_work: assert property (
    is_decrement_file_op && !dest_file |=> work_reg == $past(file_rdata) - 8'h01)
    else $error("decrement to work wrong");

  a_clear_work_reg_op_zero: assert property (
    is_clear_work_reg_op |=> work_reg == 8'h00 && zero_reg)
    else $error("clear work result wrong");

  a_dsz_flags: assert property (
    is_dsz && !wr_status |=> $stable(zero_reg))
    else $error("decrement-skip changed the zero flag");

  // zero result gives one nop cycle
  a_dsz_skip: assert property (
    is_dsz && file_rdata == 8'h01 |=>
      skip_flush && !op_ready ##1 op_ready)
    else $error("decrement-skip did not skip");

  a_zero_track: assert property (
    (is_complement_file_op || is_decrement_file_op) |=> zero_reg == ($past(alu_res) == 8'h00))
    else $error("zero flag does not follow result");

  // accepted plain ops keep the pipe flowing
  a_nop_flow: assert property (
    is_none |=> op_ready && !file_we && !stack_push)
    else $error("empty op had side effects");
endmodule // cxd_exec

/* File: cxd_exec_tb.sv */
// self-checking bench for the clear/decrement/call execute slice
// assumes cxd_pkg and cxd_exec compiled first; no separate model
module cxd_exec_tb import cxd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and op port
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  cxd_op_t op_sel = CXD_OP_NONE;
  logic op_valid = 1'b0;
  logic op_ready;
  logic [6:0] file_addr = 7'h00;
  logic dest_file = 1'b0;
  logic [7:0] file_rdata = 8'h00;
  logic file_we, stack_push, skip_flush;
  logic [6:0] file_waddr;
  logic [7:0] file_wdata, reg_rdata;
  logic [14:0] return_stack_top, pc_out;
  logic sleep_enter = 1'b0;
  logic wdog_enable = 1'b0;
  // register port
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  // shadow state of the slice
  logic [7:0] work_m = 8'h00;
  logic [6:0] latch_m = 7'h00;
  logic [14:0] pc_m = 15'h0000;
  logic z_m = 1'b0;
  logic to_m = 1'b1;
  logic pd_m = 1'b1;
  // expected results, oldest first
  logic [15:0] q_fw[$], q_sp[$], q_sk[$], q_rd[$];
  int seed = 38481;
  int err_total = 0;
  int n_tests = 0;

  // small prescaler and counter so a timeout comes quickly
  cxd_exec #(.PRE_W(2), .CNT_W(2)) dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .op_sel(op_sel),
    .op_valid(op_valid), .op_ready(op_ready), .file_addr(file_addr),
    .dest_file(dest_file), .file_rdata(file_rdata), .file_we(file_we),
    .file_waddr(file_waddr), .file_wdata(file_wdata),
    .stack_push(stack_push), .return_stack_top(return_stack_top),
    .pc_out(pc_out), .skip_flush(skip_flush), .sleep_enter(sleep_enter),
    .wdog_enable(wdog_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  // compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // status byte as the shadow state predicts it
  function logic [7:0] st_m();
    return {3'b000, to_m, pd_m, 2'b00, z_m};
  endfunction

  // predicted read data per offset
  function logic [15:0] exp_reg(input int i);
    case (i)
      0: return work_m;
      1: return latch_m;
      2: return st_m();
      3: return pc_m[7:0];
      4: return pc_m[14:8];
      default: return 16'h0000;
    endcase
  endfunction

  // one register cycle, then a gap so strobes never double up
  task rw(input logic w, input logic [2:0] a, input logic [7:0] d,
          input logic [15:0] e);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w) q_rd.push_back(e);
    if (w && a == 3'h0) work_m = d;
    if (w && a == 3'h1) latch_m = d[6:0];
    if (w && a == 3'h2) z_m = d[0];
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  // read every offset, mapped or not
  task rd_all();
    for (int i = 0; i < 8; i++) begin
      rw(1'b0, 3'(i), 8'h00, exp_reg(i));
    end
  endtask

  // offer one op, wait for ready, predict its effects at the take
  task op(input cxd_op_t o, input logic [6:0] a, input logic d,
          input logic [7:0] rd);
    logic [7:0] r;
    int k;
    op_sel <= o;
    file_addr <= a;
    dest_file <= d;
    file_rdata <= rd;
    op_valid <= 1'b1;
    k = 0;
    @(negedge clk_sys);
    while (op_ready !== 1'b1 && k < 10) begin
      @(negedge clk_sys);
      k++;
    end
    // a slot that never frees up counts as a mismatch
    check(16'(op_ready), 16'h0001);
    @(posedge clk_sys);
    r = (o == CXD_OP_COMPL) ? ~rd : (o == CXD_OP_CLR_F) ? 8'h00 : rd - 8'h01;
    pc_m = pc_m + 15'h0001;
    case (o)
      CXD_OP_NONE: begin
        // empty slot only advances the pc
      end
      CXD_OP_WDOG_CLR: begin
        to_m = 1'b1;
        pd_m = 1'b1;
      end
      CXD_OP_CALL_W: begin
        q_sp.push_back(pc_m);
        pc_m = {latch_m, work_m};
      end
      CXD_OP_CLR_W: begin
        work_m = 8'h00;
        z_m = 1'b1;
      end
      default: begin
        if (d || o == CXD_OP_CLR_F) q_fw.push_back({1'b0, a, r});
        else work_m = r;
        if (o != CXD_OP_DEC_SKIP) z_m = (r == 8'h00);
        else if (r == 8'h00) begin
          q_sk.push_back(pc_m);
          pc_m = pc_m + 15'h0001;
        end
      end
    endcase
    // second cycle refuses a new op
    if (o == CXD_OP_CALL_W || (o == CXD_OP_DEC_SKIP && r == 8'h00)) begin
      @(negedge clk_sys);
      check(op_ready, 16'h0000);
      @(posedge clk_sys);
    end
  endtask

  task idle();
    op_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  task conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // monitor: pop the oldest note whenever a result shows
  always @(posedge clk_sys) rd_d <= reg_rd;
  // outputs are unknown until the first edge under reset
  always @(negedge clk_sys) begin
    if (reset_n) begin
      if (file_we) check({1'b0, file_waddr, file_wdata},
        q_fw.size() ? q_fw.pop_front() : 'x);
      if (stack_push) check(return_stack_top,
        q_sp.size() ? q_sp.pop_front() : 'x);
      if (skip_flush) check(pc_out,
        q_sk.size() ? q_sk.pop_front() : 'x);
      check(reg_rdata, rd_d ? (q_rd.size() ? q_rd.pop_front() : 'x)
        : 16'h0000);
    end
  end

  // main sequence
  initial begin
    cxd_op_t o;
    int left;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd_all();
    // read-only and unmapped writes are ignored, then status, work and latch are written
    rw(1'b1, 3'h3, 8'hff, 16'h0000);
    rw(1'b1, 3'h5, 8'hff, 16'h0000);
    rw(1'b1, 3'h6, 8'hff, 16'h0000);
    rw(1'b1, 3'h2, 8'hff, 16'h0000);
    rw(1'b1, 3'h0, 8'ha5, 16'h0000);
    rw(1'b1, 3'h1, 8'hda, 16'h0000);
    // directed boundaries, back to back
    op(CXD_OP_CALL_W, 7'h00, 1'b0, 8'h00);
    op(CXD_OP_COMPL, 7'h7f, 1'b1, 8'hff);
    op(CXD_OP_COMPL, 7'h00, 1'b0, 8'h00);
    op(CXD_OP_DEC_F, 7'h10, 1'b0, 8'h01);
    op(CXD_OP_DEC_F, 7'h11, 1'b1, 8'h00);
    op(CXD_OP_DEC_SKIP, 7'h12, 1'b1, 8'h01);
    op(CXD_OP_DEC_SKIP, 7'h13, 1'b0, 8'h01);
    op(CXD_OP_CALL_W, 7'h00, 1'b0, 8'h00);
    op(CXD_OP_DEC_SKIP, 7'h14, 1'b0, 8'h02);
    op(CXD_OP_CLR_F, 7'h7f, 1'b0, 8'h33);
    op(CXD_OP_CLR_W, 7'h00, 1'b1, 8'h44);
    op(CXD_OP_NONE, 7'h05, 1'b1, 8'h01);
    idle();
    rd_all();
    // random mix of every op code
    for (int n = 0; n < 40; n++) begin
      o = cxd_op_t'(3'({$random(seed)} % 8));
      op(o, 7'($random(seed)), 1'($random(seed)),
        (n % 4 == 0) ? 8'h01 : 8'($random(seed)));
    end
    idle();
    rd_all();
    // power-down and timeout flags, then clear
    sleep_enter <= 1'b1;
    @(posedge clk_sys);
    sleep_enter <= 1'b0;
    pd_m = 1'b0;
    wdog_enable <= 1'b1;
    repeat (20) @(posedge clk_sys);
    wdog_enable <= 1'b0;
    to_m = 1'b0;
    rw(1'b0, 3'h2, 8'h00, st_m());
    op(CXD_OP_WDOG_CLR, 7'h00, 1'b0, 8'h00);
    idle();
    rw(1'b0, 3'h2, 8'h00, st_m());
    rw(1'b0, 3'h5, 8'h00, 16'h0000);
    // leave the prescaler part way, clear, count 3 more: no tick
    wdog_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    wdog_enable <= 1'b0;
    op(CXD_OP_WDOG_CLR, 7'h00, 1'b0, 8'h00);
    op_valid <= 1'b0;
    wdog_enable <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wdog_enable <= 1'b0;
    rw(1'b0, 3'h5, 8'h00, 16'h0000);
    rd_all();
    repeat (2) @(posedge clk_sys);
    // every noted result must have shown up
    left = q_fw.size() + q_sp.size() + q_sk.size() + q_rd.size();
    check(16'(left), 16'h0000);
    conclude();
  end

  // hang guard: the run needs about 200 cycles
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule // cxd_exec_tb
